/* File: uhs_status.sv */
// Purpose: Status register of a high-speed USB host controller.
// Assumes: Register access comes from the memory-space decoder on the core clock.
// Notes:   Read data is registered; answer follows one cycle after the request.
`timescale 1ns/100ps
`include "uhs_cfg.svh"

module uhs_status #(
    parameter int NUM_PORTS = 2
) (
    input  wire logic                   clk_sys_in,        // Core clock, 50 MHz.
    input  wire logic                   arst_n_in,         // Asynchronous reset, active low.
    input  wire logic                   clk_en_in,         // Freezes all state while low.
    input  wire uhs_pkg::uhs_req_t      req_in,            // Register read or write request.
    input  wire logic                   run_stop_bit_in,   // Run bit of command register.
    input  wire logic                   async_sched_enable_in,    // Async enable.
    input  wire logic                   periodic_sched_enable_in, // Periodic enable.
    input  wire logic                   async_active_in,   // Engine async schedule running.
    input  wire logic                   periodic_active_in, // Engine periodic running.
    input  wire logic                   empty_sched_in,    // Engine saw empty async list.
    input  wire logic                   engine_idle_in,    // Pipeline drained.
    input  wire logic                   doorbell_in,       // Doorbell write pulse.
    input  wire logic                   async_advanced_in, // Async schedule advanced pulse.
    input  wire logic                   sys_error_in,      // Host memory access error pulse.
    input  wire logic [1:0]             frame_list_size_in, // List size field.
    input  wire logic [13:0]            frame_index_in,    // Frame index counter.
    input  wire logic [NUM_PORTS-1:0]   port_change_in,    // Per-port change levels.
    input  wire logic [NUM_PORTS-1:0]   ownership_release_in, // Port released to companion.
    input  wire logic [NUM_PORTS-1:0]   force_resume_in,   // Force-resume levels.
    input  wire logic [NUM_PORTS-1:0]   suspended_in,      // Port is suspended.
    input  wire logic                   d3_to_d0_in,       // Power state return pulse.
    input  wire logic                   xact_error_in,     // Transaction error pulse.
    input  wire logic                   td_retire_in,      // Descriptor retired pulse.
    input  wire logic                   td_ioc_in,         // Retired descriptor asked interrupt.
    input  wire logic                   short_packet_in,   // Short packet pulse.
    input  wire uhs_pkg::uhs_flags_t    int_enable_in,     // Interrupt enable bits.
    output logic [31:0]                 rdata_out,         // Registered read data.
    output logic                        rvalid_out,        // Read data valid pulse.
    output logic                        run_clear_out,     // Request to clear run bit.
    output logic                        irq_out            // Interrupt to host.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    uhs_pkg::uhs_flags_t     flags_ff,   nxt_flags;
    uhs_pkg::uhs_run_state_t run_ff,     nxt_run;
    logic                    halted_ff,  nxt_halted;
    logic                    async_ff,   nxt_async;
    logic                    period_ff,  nxt_period;
    logic                    empty_ff,   nxt_empty;
    logic                    door_ff,    nxt_door;
    logic                    roll_ff,    nxt_roll;
    logic [NUM_PORTS-1:0]    pchg_ff,    nxt_pchg;
    logic [NUM_PORTS-1:0]    pres_ff,    nxt_pres;
    logic [31:0]             rdata_ff,   nxt_rdata;
    logic                    rvalid_ff,  nxt_rvalid;
    logic                    rclr_ff,    nxt_rclr;
    logic                    irq_ff,     nxt_irq;

    logic                    hit;
    logic                    roll_bit;
    logic                    port_rise;
    logic [31:0]             clr_mask;

    // Returns the flag set as a 32-bit status image.
    function automatic logic [31:0] status_image(
        input uhs_pkg::uhs_flags_t f,
        input logic a, input logic p, input logic e, input logic h
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`UHS_BIT_ASYNC_STATUS]  = a;
        v[`UHS_BIT_PERIODIC_STAT] = p;
        v[`UHS_BIT_EMPTY_DETECT]  = e;
        v[`UHS_BIT_HALTED]        = h;
        v[`UHS_BIT_ASYNC_ADVANCE] = f.async_advance;
        v[`UHS_BIT_HOST_ERROR]    = f.host_error;
        v[`UHS_BIT_ROLLOVER]      = f.rollover;
        v[`UHS_BIT_PORT_CHANGE]   = f.port_change;
        v[`UHS_BIT_XFER_ERROR]    = f.xfer_error;
        v[`UHS_BIT_XFER_DONE]     = f.xfer_done;
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Decode and event detection
    // ------------------------------------------------------------------
    // The frame index bit watched for rollover follows the list size.
    always_comb
    begin
        // The status register is the only address this block decodes; reads of any other address answer zero.
        hit = (req_in.addr == `UHS_STATUS_OFFSET);
        case (frame_list_size_in)
            `UHS_FLS_1024: roll_bit = frame_index_in[`UHS_FRIDX_BIT_1024];
            `UHS_FLS_512:  roll_bit = frame_index_in[`UHS_FRIDX_BIT_512];
            default:       roll_bit = frame_index_in[`UHS_FRIDX_BIT_256];
        endcase
        // Only owned ports, and resume only on suspended ports, count.
        port_rise = |(port_change_in & ~pchg_ff & ~ownership_release_in)
                  | |(force_resume_in & ~pres_ff & suspended_in & ~ownership_release_in);
        // Write-one-to-clear mask, only for bytes that are enabled.
        clr_mask = 32'h0000_0000;
        if (hit && req_in.wr)
        begin
            clr_mask = req_in.wdata & {{8{req_in.be[3]}}, {8{req_in.be[2]}},
                                       {8{req_in.be[1]}}, {8{req_in.be[0]}}};
        end
    end

    // ------------------------------------------------------------------
    // Flag next values
    // ------------------------------------------------------------------
    // Hardware set wins over a software clear in the same cycle.
    always_comb
    begin
        nxt_flags = flags_ff;
        if (clr_mask[`UHS_BIT_ASYNC_ADVANCE]) nxt_flags.async_advance = 1'b0;
        if (clr_mask[`UHS_BIT_HOST_ERROR])    nxt_flags.host_error    = 1'b0;
        if (clr_mask[`UHS_BIT_ROLLOVER])      nxt_flags.rollover      = 1'b0;
        if (clr_mask[`UHS_BIT_PORT_CHANGE])   nxt_flags.port_change   = 1'b0;
        if (clr_mask[`UHS_BIT_XFER_ERROR])    nxt_flags.xfer_error    = 1'b0;
        if (clr_mask[`UHS_BIT_XFER_DONE])     nxt_flags.xfer_done     = 1'b0;
        // The doorbell is remembered until the engine next advances the async list;
        // an advance in the same cycle as the doorbell does not count for it.
        nxt_door = door_ff | doorbell_in;
        if (door_ff && async_advanced_in)
        begin
            nxt_flags.async_advance = 1'b1;
            nxt_door = doorbell_in;
        end
        if (sys_error_in)
        begin
            nxt_flags.host_error = 1'b1;
        end
        // Any change of the watched index bit marks a wrap of the frame list.
        // The bit is compared with its last sample, so both toggle directions count.
        nxt_roll = roll_bit;
        if (roll_bit != roll_ff)
        begin
            nxt_flags.rollover = 1'b1;
        end
        // Previous port levels let a rise be told apart from a standing level.
        nxt_pchg = port_change_in;
        nxt_pres = force_resume_in;
        if (port_rise)
        begin
            nxt_flags.port_change = 1'b1;
        end
        // On return to full power the flag is rebuilt from the port levels.
        if (d3_to_d0_in)
        begin
            nxt_flags.port_change = |(port_change_in | force_resume_in);
        end
        // A failed transaction whose descriptor asked for a completion interrupt
        // reports through both the error flag and the completion flag.
        if (xact_error_in)
        begin
            nxt_flags.xfer_error = 1'b1;
            if (td_ioc_in)
            begin
                nxt_flags.xfer_done = 1'b1;
            end
        end
        if ((td_retire_in && td_ioc_in) || short_packet_in)
        begin
            nxt_flags.xfer_done = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Run, halt and schedule status next values
    // ------------------------------------------------------------------
    // Halted clears with the run bit and sets only after the pipeline drains or on an illegal state code.
    always_comb
    begin
        nxt_run    = run_ff;
        nxt_halted = halted_ff;
        nxt_rclr   = sys_error_in;
        // A host error starts the drain at once, before the run bit is cleared.
        case (run_ff)
            uhs_pkg::UHS_HALTED:
            begin
                if (run_stop_bit_in)
                begin
                    nxt_run    = uhs_pkg::UHS_RUNNING;
                    nxt_halted = 1'b0;
                end
            end
            uhs_pkg::UHS_RUNNING:
            begin
                if (!run_stop_bit_in || sys_error_in)
                begin
                    nxt_run = uhs_pkg::UHS_DRAINING;
                end
            end
            uhs_pkg::UHS_DRAINING:
            begin
                if (engine_idle_in && !run_stop_bit_in)
                begin
                    nxt_run    = uhs_pkg::UHS_HALTED;
                    nxt_halted = 1'b1;
                end
            end
            // An illegal state code falls back to the halted state.
            default:
            begin
                nxt_run    = uhs_pkg::UHS_HALTED;
                nxt_halted = 1'b1;
            end
        endcase
        // Status mirrors what the engine really does, not the enable bits.
        nxt_async  = async_active_in;
        nxt_period = periodic_active_in;
        nxt_empty  = empty_sched_in;
    end

    // ------------------------------------------------------------------
    // Read data and interrupt next values
    // ------------------------------------------------------------------
    // Read data is captured for a status read; any other read answers zero.
    // The interrupt uses the next flag values so it rises with the flag itself.
    always_comb
    begin
        nxt_rvalid = req_in.rd;
        nxt_rdata  = 32'h0000_0000;
        if (req_in.rd && hit)
        begin
            nxt_rdata = status_image(flags_ff, async_ff, period_ff, empty_ff, halted_ff);
        end
        nxt_irq = |(nxt_flags & int_enable_in);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // All state holds while the clock enable is low; reset wins over the enable.
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            flags_ff  <= '0;
            run_ff    <= uhs_pkg::UHS_HALTED;
            halted_ff <= `UHS_HALTED_RESET;
            async_ff  <= 1'b0;
            period_ff <= 1'b0;
            empty_ff  <= 1'b0;
            door_ff   <= 1'b0;
            roll_ff   <= 1'b0;
            pchg_ff   <= '0;
            pres_ff   <= '0;
            rdata_ff  <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
            rclr_ff   <= 1'b0;
            irq_ff    <= 1'b0;
        end
        else if (clk_en_in)
        begin
            flags_ff  <= nxt_flags;
            run_ff    <= nxt_run;
            halted_ff <= nxt_halted;
            async_ff  <= nxt_async;
            period_ff <= nxt_period;
            empty_ff  <= nxt_empty;
            door_ff   <= nxt_door;
            roll_ff   <= nxt_roll;
            pchg_ff   <= nxt_pchg;
            pres_ff   <= nxt_pres;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            rclr_ff   <= nxt_rclr;
            irq_ff    <= nxt_irq;
        end
    end

    // Outputs come straight from flip-flops.
    assign rdata_out     = rdata_ff;
    assign rvalid_out    = rvalid_ff;
    assign run_clear_out = rclr_ff;
    assign irq_out       = irq_ff;

endmodule

/* File: uhs_cfg.svh */
// Purpose: Constants for the host status register block.
// Assumes: Register offsets are byte addresses within the operational space.
// Notes:   Every offset and field position, and the halted reset value, lives here.
`ifndef UHS_CFG_SVH
`define UHS_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define UHS_STATUS_OFFSET      8'h24

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define UHS_BIT_ASYNC_STATUS   15
`define UHS_BIT_PERIODIC_STAT  14
`define UHS_BIT_EMPTY_DETECT   13
`define UHS_BIT_HALTED         12
`define UHS_BIT_ASYNC_ADVANCE  5
`define UHS_BIT_HOST_ERROR     4
`define UHS_BIT_ROLLOVER       3
`define UHS_BIT_PORT_CHANGE    2
`define UHS_BIT_XFER_ERROR     1
`define UHS_BIT_XFER_DONE      0

// ----------------------------------------------------------------------
// Reset values and list sizes
// ----------------------------------------------------------------------
`define UHS_HALTED_RESET       1'h1
`define UHS_FLS_1024           2'h0
`define UHS_FLS_512            2'h1
`define UHS_FLS_256            2'h2
`define UHS_FRIDX_BIT_1024     13
`define UHS_FRIDX_BIT_512      12
`define UHS_FRIDX_BIT_256      11

`endif

/* File: uhs_pkg.sv */
// Purpose: Types shared by the host status register block.
// Assumes: Used with uhs_cfg.svh for constants.
// Notes:   Nothing here is imported; users write uhs_pkg::name.
package uhs_pkg;

    // ------------------------------------------------------------------
    // Event flags set by the controller core
    // ------------------------------------------------------------------
    typedef struct packed {
        logic async_advance;
        logic host_error;
        logic rollover;
        logic port_change;
        logic xfer_error;
        logic xfer_done;
    } uhs_flags_t;

    // ------------------------------------------------------------------
    // Register access request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } uhs_req_t;

    // ------------------------------------------------------------------
    // Halt sequencing states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        UHS_HALTED   = 3'b001,
        UHS_RUNNING  = 3'b010,
        UHS_DRAINING = 3'b100
    } uhs_run_state_t;

endpackage

/* File: uhs_status_props.sv */
// Purpose: Port-level checks for the host status register block.
// Assumes: One core clock and an asynchronous active-low reset.
// Notes:   Bound to every uhs_status instance below the module.
`timescale 1ns/100ps
`include "uhs_cfg.svh"

module uhs_status_props (
    input wire logic                clk_sys_in,         // Core clock.
    input wire logic                arst_n_in,          // Reset, active low.
    input wire logic                clk_en_in,          // Clock enable.
    input wire uhs_pkg::uhs_req_t   req_in,             // Register request.
    input wire logic                run_stop_bit_in,    // Run bit.
    input wire logic                async_active_in,    // Async engine running.
    input wire logic                periodic_active_in, // Periodic engine running.
    input wire logic                empty_sched_in,     // Empty list seen.
    input wire logic                sys_error_in,       // Host memory error.
    input wire logic                xact_error_in,      // Transaction error.
    input wire logic [1:0]          frame_list_size_in, // List size.
    input wire logic [13:0]         frame_index_in,     // Frame index.
    input wire uhs_pkg::uhs_flags_t int_enable_in,      // Interrupt enables.
    input wire logic [31:0]         rdata_out,          // Read data.
    input wire logic                rvalid_out,         // Read valid.
    input wire logic                run_clear_out,      // Run bit clear request.
    input wire logic                irq_out             // Interrupt.
);
    logic rd_hit;

    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);

    // A status read taken on an enabled edge.
    assign rd_hit = clk_en_in && req_in.rd && (req_in.addr == `UHS_STATUS_OFFSET);

    reserved_zero_a: assert property (rd_hit |=> rvalid_out
        && rdata_out[31:16] == 16'h0000 && rdata_out[11:6] == 6'h00)
        else $error("status read answer wrong");
    read_quiet_a: assert property (clk_en_in && !req_in.rd |=> !rvalid_out)
        else $error("read valid without a read");
    unmapped_zero_a: assert property (clk_en_in && req_in.rd
        && req_in.addr != `UHS_STATUS_OFFSET |=> rdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    sched_mirror_a: assert property (rd_hit && $past(arst_n_in) && $past(clk_en_in)
        && $stable({async_active_in, periodic_active_in, empty_sched_in})
        |=> rdata_out[15:13] == $past({async_active_in, periodic_active_in, empty_sched_in}))
        else $error("schedule status bits wrong");
    run_not_halted_a: assert property (rd_hit && run_stop_bit_in && $past(run_stop_bit_in)
        && $past(clk_en_in) && $past(arst_n_in) |=> !rdata_out[`UHS_BIT_HALTED])
        else $error("halted while running");
    error_stops_run_a: assert property (clk_en_in |=> run_clear_out == $past(sys_error_in))
        else $error("run clear pulse wrong");
    host_error_irq_a: assert property (clk_en_in && sys_error_in && int_enable_in.host_error
        |=> irq_out)
        else $error("host error interrupt missing");
    xfer_error_irq_a: assert property (clk_en_in && xact_error_in && int_enable_in.xfer_error
        |=> irq_out)
        else $error("transfer error interrupt missing");
    rollover_irq_a: assert property (clk_en_in && $past(clk_en_in) && $past(arst_n_in)
        && frame_list_size_in == 2'h0 && $changed(frame_index_in[13])
        && int_enable_in.rollover |=> irq_out)
        else $error("rollover interrupt missing");

    // Main scenarios reached.
    flag_read_c: cover property (rd_hit ##1 rdata_out[5:0] != 6'h00);
    run_clear_c: cover property (run_clear_out);
    irq_drop_c: cover property (irq_out ##1 !irq_out);
endmodule

bind uhs_status uhs_status_props uhs_status_props_i (
    .clk_sys_in, .arst_n_in, .clk_en_in, .req_in, .run_stop_bit_in, .async_active_in,
    .periodic_active_in, .empty_sched_in, .sys_error_in, .xact_error_in, .frame_list_size_in,
    .frame_index_in, .int_enable_in, .rdata_out, .rvalid_out, .run_clear_out, .irq_out
);

/* File: uhs_status_test.sv */
// Purpose: Self-checking bench for the host status register block.
// Assumes: Reads answer one cycle after the request edge.
// Notes:   Reads note expectations in a queue; a monitor compares answers.
`timescale 1ns/100ps
`include "uhs_cfg.svh"

module uhs_status_test;
    logic clk_sys_in = 1'b0, arst_n_in = 1'b0, clk_en_in, run_stop_bit_in, engine_idle_in;
    logic async_sched_enable_in, periodic_sched_enable_in, async_active_in, periodic_active_in;
    logic empty_sched_in, doorbell_in, async_advanced_in, sys_error_in, d3_to_d0_in;
    logic xact_error_in, td_retire_in, td_ioc_in, short_packet_in, rvalid_out, run_clear_out;
    logic [1:0]  frame_list_size_in, port_change_in, ownership_release_in, force_resume_in;
    logic [1:0]  suspended_in;
    logic [13:0] frame_index_in;
    logic [31:0] rdata_out, seed = 32'h0000_001C;
    logic [5:0]  exp_fl = 6'h00;
    logic        exp_halt = 1'b1, irq_out;
    logic [32:0] expq[$];
    logic        rclrq[$];
    int          failures = 0, comparisons = 0;
    uhs_pkg::uhs_req_t   req_in;
    uhs_pkg::uhs_flags_t int_enable_in;

    uhs_status #(.NUM_PORTS(2)) uhs_status_i (
        .clk_sys_in, .arst_n_in, .clk_en_in, .req_in, .run_stop_bit_in, .async_sched_enable_in,
        .periodic_sched_enable_in, .async_active_in, .periodic_active_in, .empty_sched_in,
        .engine_idle_in, .doorbell_in, .async_advanced_in, .sys_error_in, .frame_list_size_in,
        .frame_index_in, .port_change_in, .ownership_release_in, .force_resume_in,
        .suspended_in, .d3_to_d0_in, .xact_error_in, .td_retire_in, .td_ioc_in,
        .short_packet_in, .int_enable_in, .rdata_out, .rvalid_out, .run_clear_out, .irq_out
    );

    // Free-running 50 MHz clock.
    always #10 clk_sys_in = ~clk_sys_in;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #2;
    endtask

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Reads the register at a, with random enables, and notes irq and data.
    task automatic rd_at(input logic [7:0] a);
        logic [31:0] exp;
        seed = xs(seed);
        int_enable_in = uhs_pkg::uhs_flags_t'(seed[5:0]);
        exp = {16'h0000, async_active_in, periodic_active_in, empty_sched_in, exp_halt,
               6'h00, exp_fl};
        if (a != `UHS_STATUS_OFFSET)
            exp = 32'h0000_0000;
        expq.push_back({|(exp_fl & seed[5:0]), exp});
        req_in = '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: 32'h0000_0000};
        tick(1);
        req_in = '0;
        tick(1);
    endtask

    task automatic wr_at(input logic [31:0] d, input logic [3:0] en);
        req_in = '{rd: 1'b0, wr: 1'b1, addr: `UHS_STATUS_OFFSET, be: en, wdata: d};
        tick(1);
        req_in = '0;
        if (en[0])
            exp_fl = exp_fl & ~d[5:0];
        tick(1);
    endtask

    task automatic clr_all;
        seed = xs(seed);
        wr_at({seed[31:6], 6'h3F}, 4'hF);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask

    // Pulses one event source, checks the flags it set, then clears them.
    // Enables the expected flags so the interrupt path is exercised too.
    task automatic ev(ref logic s, input logic [5:0] sets);
        int_enable_in = uhs_pkg::uhs_flags_t'(sets);
        if (sets[4])
            rclrq.push_back(1'b1);
        pulse(s);
        exp_fl = exp_fl | sets;
        rd_at(`UHS_STATUS_OFFSET);
        clr_all();
        rd_at(`UHS_STATUS_OFFSET);
    endtask

    // Compares each read answer and run clear pulse with the oldest noted expectation.
    always @(posedge clk_sys_in)
    begin
        if (rvalid_out === 1'b1 && expq.size() == 0)
            chk("unrequested read", 33'h0, 33'h1);
        else if (rvalid_out === 1'b1)
            chk("status read", expq.pop_front(), {irq_out, rdata_out});
        if (run_clear_out === 1'b1 && rclrq.size() == 0)
            chk("unrequested run clear", 33'h0, 33'h1);
        else if (run_clear_out === 1'b1)
            chk("run clear", {32'h0000_0000, rclrq.pop_front()}, 33'h1);
    end

    // Cuts a hung run short.
    initial
    begin
        #(20 * 3000);
        failures++;
        final_report();
    end

    // Main sequence.
    initial
    begin
        {run_stop_bit_in, engine_idle_in, async_sched_enable_in, periodic_sched_enable_in} = '0;
        {async_active_in, periodic_active_in, empty_sched_in, doorbell_in, async_advanced_in} = '0;
        {sys_error_in, d3_to_d0_in, xact_error_in, td_retire_in, td_ioc_in, short_packet_in} = '0;
        {frame_list_size_in, port_change_in, ownership_release_in, force_resume_in} = '0;
        {suspended_in, frame_index_in, int_enable_in, req_in} = '0;
        clk_en_in = 1'b1;
        tick(6);
        arst_n_in = 1'b1;
        tick(1);
        rd_at(`UHS_STATUS_OFFSET);
        rd_at(8'h30);
        {async_sched_enable_in, periodic_sched_enable_in} = 2'h3;
        tick(2);
        rd_at(`UHS_STATUS_OFFSET);
        {async_active_in, periodic_active_in, empty_sched_in} = 3'h7;
        tick(1);
        rd_at(`UHS_STATUS_OFFSET);
        {async_active_in, periodic_active_in, empty_sched_in} = 3'h2;
        run_stop_bit_in = 1'b1;
        tick(2);
        exp_halt = 1'b0;
        rd_at(`UHS_STATUS_OFFSET);
        run_stop_bit_in = 1'b0;
        tick(3);
        rd_at(`UHS_STATUS_OFFSET);
        engine_idle_in = 1'b1;
        tick(3);
        exp_halt = 1'b1;
        rd_at(`UHS_STATUS_OFFSET);
        ev(async_advanced_in, 6'h00);
        pulse(doorbell_in);
        ev(async_advanced_in, 6'h20);
        ev(sys_error_in, 6'h10);
        ev(xact_error_in, 6'h02);
        td_ioc_in = 1'b1;
        ev(xact_error_in, 6'h03);
        ev(td_retire_in, 6'h01);
        td_ioc_in = 1'b0;
        ev(td_retire_in, 6'h00);
        ev(short_packet_in, 6'h01);
        clk_en_in = 1'b0;
        pulse(xact_error_in);
        clk_en_in = 1'b1;
        rd_at(`UHS_STATUS_OFFSET);
        for (int f = 0; f < 3; f++)
        begin
            frame_list_size_in = f[1:0];
            frame_index_in = 14'h0001 << (12 - f);
            tick(1);
            rd_at(`UHS_STATUS_OFFSET);
            frame_index_in = 14'h0001 << (13 - f);
            int_enable_in.rollover = 1'b1;
            tick(1);
            exp_fl[3] = 1'b1;
            rd_at(`UHS_STATUS_OFFSET);
            frame_index_in = 14'h0000;
            tick(1);
            clr_all();
        end
        {ownership_release_in, port_change_in} = 4'hA;
        tick(1);
        rd_at(`UHS_STATUS_OFFSET);
        port_change_in = 2'h3;
        tick(1);
        exp_fl[2] = 1'b1;
        rd_at(`UHS_STATUS_OFFSET);
        clr_all();
        force_resume_in = 2'h1;
        tick(1);
        rd_at(`UHS_STATUS_OFFSET);
        {force_resume_in, suspended_in} = 4'h1;
        tick(1);
        force_resume_in = 2'h1;
        tick(1);
        exp_fl[2] = 1'b1;
        rd_at(`UHS_STATUS_OFFSET);
        clr_all();
        port_change_in = 2'h2;
        pulse(d3_to_d0_in);
        exp_fl[2] = 1'b1;
        rd_at(`UHS_STATUS_OFFSET);
        wr_at(32'hFFFF_FFFF, 4'hE);
        wr_at(32'h0000_0000, 4'hF);
        rd_at(`UHS_STATUS_OFFSET);
        clr_all();
        rd_at(`UHS_STATUS_OFFSET);
        tick(2);
        chk("pending reads", 33'h0, 33'(expq.size()));
        chk("pending run clears", 33'h0, 33'(rclrq.size()));
        final_report();
    end
endmodule
